// ---- pkg/emt_defs.vh ----
`ifndef EMT_DEFS_VH
`define EMT_DEFS_VH
`define EMT_TC_ADDR 8'h84
`define EMT_TC_RESET 8'hFF
`define EMT_TC_SETUP_HI 7
`define EMT_TC_SETUP_LO 6
`define EMT_TC_WIDTH_HI 5
`define EMT_TC_WIDTH_LO 2
`define EMT_TC_HOLD_HI 1
`define EMT_TC_HOLD_LO 0
`define EMT_MODE_MUX_NB0 3'h1
`define EMT_MODE_MUX_BS 3'h2
`define EMT_MODE_MUX_NB1 3'h3
`define EMT_MODE_SEP_NB0 3'h5
`define EMT_MODE_SEP_BS 3'h6
`define EMT_MODE_SEP_NB1 3'h7
`define EMT_EXTRA_CYCLES 4
`endif

// ---- rtl/emt_ext_mem_timing.v ----
`timescale 1ns/10ps
`include "emt_defs.vh"
module emt_ext_mem_timing (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire [2:0] bus_mux_select_i,
    input wire [1:0] latch_pulse_width_i,
    input wire [7:0] ext_mem_page_select_i,
    input wire [7:0] indirect_pointer_a_i,
    input wire [7:0] indirect_pointer_b_i,
    input wire [15:0] wide_data_pointer_i,
    input wire req_i,
    input wire req_write_i,
    input wire req_wide_i,
    input wire req_ptr_b_i,
    input wire [7:0] req_wdata_i,
    output reg busy_o,
    output reg done_o,
    output reg [7:0] rdata_o,
    output reg [7:0] addr_hi_o,
    output reg addr_hi_oe_o,
    output reg [7:0] addr_lo_o,
    output reg addr_lo_oe_o,
    output reg [7:0] data_o,
    output reg data_oe_o,
    input wire [7:0] data_i,
    output reg ale_o,
    output reg wr_n_o,
    output reg rd_n_o
);
    localparam S_IDLE = 7'h01;
    localparam S_ALEH = 7'h02;
    localparam S_ALEL = 7'h04;
    localparam S_SETUP = 7'h08;
    localparam S_STRB = 7'h10;
    localparam S_HOLD = 7'h20;
    localparam S_TAIL = 7'h40;
    // Entry decode and hold exit take two of the fixed extra cycles, the tail the rest
    localparam [4:0] TAIL_LOAD = 5'd`EMT_EXTRA_CYCLES - 5'd3;

    reg [7:0] tc_q;
    reg [6:0] st_q;
    reg [6:0] st_d;
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;
    reg wr_q;
    reg [7:0] wd_q;
    reg [1:0] lw_q;

    // Mode decode for multiplexed operation
    function emt_is_mux;
        input [2:0] mode;
        begin
            emt_is_mux = (mode == `EMT_MODE_MUX_NB0) || (mode == `EMT_MODE_MUX_BS) ||
                (mode == `EMT_MODE_MUX_NB1);
        end
    endfunction

    function emt_is_sep;
        input [2:0] mode;
        begin
            emt_is_sep = (mode == `EMT_MODE_SEP_NB0) || (mode == `EMT_MODE_SEP_BS) ||
                (mode == `EMT_MODE_SEP_NB1);
        end
    endfunction

    function emt_has_bank;
        input [2:0] mode;
        begin
            emt_has_bank = (mode == `EMT_MODE_MUX_BS) || (mode == `EMT_MODE_SEP_BS);
        end
    endfunction

    // Low address byte of an access
    function [7:0] emt_low_addr;
        input wide;
        input use_b;
        input [7:0] ptr_a;
        input [7:0] ptr_b;
        input [15:0] wide_ptr;
        begin
            if (wide) begin
                emt_low_addr = wide_ptr[7:0];
            end else if (use_b) begin
                emt_low_addr = ptr_b;
            end else begin
                emt_low_addr = ptr_a;
            end
        end
    endfunction

    function [4:0] emt_count2;
        input [1:0] field;
        begin
            emt_count2 = {3'b000, field};
        end
    endfunction

    // Timing fields of the control register
    wire [1:0] setup_f = tc_q[`EMT_TC_SETUP_HI:`EMT_TC_SETUP_LO];
    wire [3:0] width_f = tc_q[`EMT_TC_WIDTH_HI:`EMT_TC_WIDTH_LO];
    wire [1:0] hold_f = tc_q[`EMT_TC_HOLD_HI:`EMT_TC_HOLD_LO];
    wire mode_mux = emt_is_mux(bus_mux_select_i);
    wire mode_sep = emt_is_sep(bus_mux_select_i);
    wire mode_bank = emt_has_bank(bus_mux_select_i);
    wire [7:0] lo_addr = emt_low_addr(req_wide_i, req_ptr_b_i, indirect_pointer_a_i, indirect_pointer_b_i,
        wide_data_pointer_i);
    wire start = req_i && (st_q == S_IDLE) && (mode_mux || mode_sep);
    wire last = (cnt_q == 5'h00);

    // Register write/read at one address, independent of page
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tc_q <= `EMT_TC_RESET;
            sfr_rdata_o <= 8'h00;
        end else begin
            if (sfr_wr_i && sfr_addr_i == `EMT_TC_ADDR) begin
                tc_q <= sfr_wdata_i;
            end
            if (sfr_rd_i && sfr_addr_i == `EMT_TC_ADDR) begin
                sfr_rdata_o <= tc_q;
            end else begin
                sfr_rdata_o <= 8'h00;
            end
        end
    end

    // Next state and cycle count of one off-chip access
    always @* begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            S_IDLE: begin
                if (start) begin
                    if (mode_mux) begin
                        cnt_d = emt_count2(latch_pulse_width_i);
                        st_d = S_ALEH;
                    end else begin
                        cnt_d = emt_count2(setup_f);
                        st_d = S_SETUP;
                    end
                end
            end
            S_ALEH: begin
                if (last) begin
                    cnt_d = emt_count2(lw_q);
                    st_d = S_ALEL;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            S_ALEL: begin
                if (last) begin
                    cnt_d = emt_count2(setup_f);
                    st_d = S_SETUP;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            S_SETUP: begin
                if (last) begin
                    cnt_d = {1'b0, width_f};
                    st_d = S_STRB;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            S_STRB: begin
                if (last) begin
                    cnt_d = emt_count2(hold_f);
                    st_d = S_HOLD;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            S_HOLD: begin
                if (last) begin
                    cnt_d = TAIL_LOAD;
                    st_d = S_TAIL;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            S_TAIL: begin
                if (last) begin
                    st_d = S_IDLE;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            default: begin
                st_d = S_IDLE;
                cnt_d = 5'h00;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= S_IDLE;
            cnt_q <= 5'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Pins, handshake and captured data follow the state register
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= 1'b0;
            wd_q <= 8'h00;
            lw_q <= 2'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            addr_hi_o <= 8'h00;
            addr_hi_oe_o <= 1'b0;
            addr_lo_o <= 8'h00;
            addr_lo_oe_o <= 1'b0;
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            ale_o <= 1'b0;
            wr_n_o <= 1'b1;
            rd_n_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        busy_o <= 1'b1;
                        wr_q <= req_write_i;
                        wd_q <= req_wdata_i;
                        lw_q <= latch_pulse_width_i;
                        if (req_wide_i) begin
                            addr_hi_o <= wide_data_pointer_i[15:8];
                            addr_hi_oe_o <= 1'b1;
                        end else if (mode_bank) begin
                            addr_hi_o <= ext_mem_page_select_i;
                            addr_hi_oe_o <= 1'b1;
                        end else begin
                            addr_hi_oe_o <= 1'b0;
                        end
                        if (mode_mux) begin
                            addr_lo_o <= 8'h00;
                            addr_lo_oe_o <= 1'b0;
                            data_o <= lo_addr;
                            data_oe_o <= 1'b1;
                            ale_o <= 1'b1;
                        end else begin
                            addr_lo_o <= lo_addr;
                            addr_lo_oe_o <= 1'b1;
                            data_o <= req_wdata_i;
                            data_oe_o <= req_write_i;
                        end
                    end
                end
                S_ALEH: begin
                    if (last) begin
                        ale_o <= 1'b0;
                    end
                end
                S_ALEL: begin
                    if (last) begin
                        data_o <= wd_q;
                        data_oe_o <= wr_q;
                    end
                end
                S_SETUP: begin
                    if (last) begin
                        wr_n_o <= ~wr_q;
                        rd_n_o <= wr_q;
                    end
                end
                S_STRB: begin
                    if (last) begin
                        if (!wr_q) begin
                            rdata_o <= data_i;
                        end
                        wr_n_o <= 1'b1;
                        rd_n_o <= 1'b1;
                    end
                end
                S_HOLD: begin
                    if (last) begin
                        addr_hi_oe_o <= 1'b0;
                        addr_lo_oe_o <= 1'b0;
                        data_oe_o <= 1'b0;
                    end
                end
                S_TAIL: begin
                    if (last) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
                default: begin
                    busy_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // emt_ext_mem_timing

// ---- sim/emt_ext_mem_timing_properties.sv ----
`timescale 1ns/10ps
module emt_ext_mem_timing_properties (
    input wire sys_clk_i, reset_n_i, sfr_wr_i, sfr_rd_i, busy_o, done_o, addr_hi_oe_o, addr_lo_oe_o,
    input wire data_oe_o, ale_o, wr_n_o, rd_n_o,
    input wire [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, addr_hi_o, addr_lo_o,
    input wire [2:0] bus_mux_select_i
);
    logic [7:0] tc_q;
    logic [4:0] cnt_q;
    wire stb = !wr_n_o || !rd_n_o;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Shadow timing register and strobe length counter
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tc_q <= 8'hFF;
            cnt_q <= 5'h00;
        end else begin
            if (sfr_wr_i && sfr_addr_i == 8'h84) tc_q <= sfr_wdata_i;
            cnt_q <= stb ? cnt_q + 5'h01 : 5'h00;
        end
    end
    property p_one; !(!wr_n_o && !rd_n_o); endproperty
    a_one: assert property (p_one) else $error("both strobes low");
    property p_frz; stb && $past(stb) |-> $stable({addr_hi_o, addr_lo_o, addr_hi_oe_o, addr_lo_oe_o}); endproperty
    a_frz: assert property (p_frz) else $error("address moved in strobe");
    property p_wid; $fell(stb) |-> cnt_q == {1'h0, tc_q[5:2]} + 5'h01; endproperty
    a_wid: assert property (p_wid) else $error("strobe width");
    property p_ale; ale_o |-> !stb && !bus_mux_select_i[2]; endproperty
    a_ale: assert property (p_ale) else $error("latch enable misplaced");
    property p_mux; busy_o && !bus_mux_select_i[2] |-> !addr_lo_oe_o; endproperty
    a_mux: assert property (p_mux) else $error("low address pins driven");
    property p_bsy; stb |-> busy_o; endproperty
    a_bsy: assert property (p_bsy) else $error("strobe while idle");
    property p_done; done_o |=> !done_o; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_rd; !rd_n_o |-> !data_oe_o; endproperty
    a_rd: assert property (p_rd) else $error("data driven in read");
    property p_reg; sfr_rd_i && sfr_addr_i == 8'h84 |=> sfr_rdata_o == $past(tc_q); endproperty
    a_reg: assert property (p_reg) else $error("timing readback");
    c_rd: cover property (!rd_n_o);
    c_ale: cover property (ale_o);
    c_done: cover property (done_o && !bus_mux_select_i[2]);
endmodule // emt_ext_mem_timing_properties
bind emt_ext_mem_timing emt_ext_mem_timing_properties u_emt_ext_mem_timing_properties (.*);

// ---- sim/emt_sram_model.sv ----
`timescale 1ns/10ps
module emt_sram_model (
    input wire sys_clk_i, ale_i, wr_n_i, rd_n_i, hi_oe_i, lo_oe_i,
    input wire [7:0] hi_i, lo_i, ad_i,
    output wire [7:0] q_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat_q;
    wire [15:0] a = {hi_oe_i ? hi_i : 8'h00, lo_oe_i ? lo_i : lat_q};
    // Address latch follows the shared port while enabled
    always @(posedge sys_clk_i) begin
        if (ale_i) lat_q <= ad_i;
        if (!wr_n_i) mem[a] <= ad_i;
    end
    // Outside a read the port shows the inverse, never stale data
    assign q_o = rd_n_i ? ~mem[a] : mem[a];
endmodule // emt_sram_model

// ---- sim/emt_ext_mem_timing_tb.sv ----
`timescale 1ns/10ps
module emt_ext_mem_timing_tb;
    logic sys_clk_i = 1'h0, reset_n_i = 1'h0, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0, req_i = 1'h0;
    logic req_write_i = 1'h0, req_wide_i = 1'h0, req_ptr_b_i = 1'h0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, req_wdata_i = 8'h00, tc = 8'hFF;
    logic [7:0] ext_mem_page_select_i = 8'h3C, indirect_pointer_a_i = 8'h51, indirect_pointer_b_i = 8'hA2;
    logic [7:0] tcs [3] = '{8'h00, 8'h49, 8'hB6};
    logic [2:0] bus_mux_select_i = 3'h5;
    logic [1:0] latch_pulse_width_i = 2'h0;
    logic [15:0] wide_data_pointer_i = 16'hB7C4;
    wire busy_o, done_o, addr_hi_oe_o, addr_lo_oe_o, data_oe_o, ale_o, wr_n_o, rd_n_o;
    wire [7:0] sfr_rdata_o, rdata_o, addr_hi_o, addr_lo_o, data_o, data_i;
    int mismatches = 0, n_compared = 0;
    emt_ext_mem_timing u_emt_ext_mem_timing (.*);
    emt_sram_model u_emt_sram_model (.sys_clk_i, .ale_i(ale_o), .wr_n_i(wr_n_o), .rd_n_i(rd_n_o),
        .hi_oe_i(addr_hi_oe_o), .lo_oe_i(addr_lo_oe_o), .hi_i(addr_hi_o), .lo_i(addr_lo_o), .ad_i(data_o), .q_o(data_i));
    always #2 sys_clk_i = ~sys_clk_i;
    task chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task sfr(input logic w, input logic [7:0] a, d);
        @(negedge sys_clk_i);
        {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {w, !w, a, d};
        @(negedge sys_clk_i);
        {sfr_wr_i, sfr_rd_i} = 2'h0;
        if (!w) chk(sfr_rdata_o, d);
    endtask
    task xfer(input logic [2:0] m, input logic w, wide, b, input logic [7:0] d);
        int k, n, na, ns;
        logic [8:0] hi;
        logic [7:0] lo;
        logic [1:0] s;
        n = tc[7:6] + tc[5:2] + tc[1:0] + 5 + (m[2] ? 0 : 2 * (latch_pulse_width_i + 1));
        k = 0;
        na = 0;
        ns = 0;
        {hi, lo, s} = 19'h00000;
        @(negedge sys_clk_i);
        {bus_mux_select_i, req_write_i, req_wide_i, req_ptr_b_i, req_wdata_i, req_i} = {m, w, wide, b, d, 1'h1};
        @(negedge sys_clk_i);
        req_i = 1'h0;
        while (done_o !== 1'h1 && k < 300) begin
            if (ale_o) begin
                lo = data_o;
                na++;
            end
            if (!wr_n_o || !rd_n_o) begin
                ns++;
                hi = {addr_hi_oe_o, addr_hi_oe_o ? addr_hi_o : 8'h00};
                if (addr_lo_oe_o) lo = addr_lo_o;
                s = s | {!wr_n_o, !rd_n_o};
            end
            @(negedge sys_clk_i);
            k++;
        end
        chk(k[15:0], n[15:0]);
        chk(ns[15:0], {12'h000, tc[5:2]} + 16'h0001);
        chk(na[15:0], m[2] ? 16'h0000 : {14'h0000, latch_pulse_width_i} + 16'h0001);
        chk(s, {w, !w});
        chk(lo, wide ? wide_data_pointer_i[7:0] : b ? indirect_pointer_b_i : indirect_pointer_a_i);
        chk(hi, wide ? {1'h1, wide_data_pointer_i[15:8]} : m[1:0] == 2'h2 ? {1'h1, ext_mem_page_select_i} : 9'h000);
        if (!w) chk(rdata_o, d);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_n_i = 1'h1;
        sfr(1'h0, 8'h84, 8'hFF);
        sfr(1'h0, 8'h85, 8'h00);
        xfer(3'h5, 1'h1, 1'h1, 1'h0, 8'h5A);
        foreach (tcs[i]) begin
            tc = tcs[i];
            latch_pulse_width_i = tc[3:2];
            sfr(1'h1, 8'h84, tc);
            sfr(1'h0, 8'h84, tc);
            for (int m = 1; m < 8; m++) begin
                for (int j = 0; j < 2 && m != 4; j++) begin
                    xfer(m[2:0], 1'h1, j[0], m[0] ^ j[0], {tc[3:0], j[0], m[2:0]});
                    xfer(m[2:0], 1'h0, j[0], m[0] ^ j[0], {tc[3:0], j[0], m[2:0]});
                end
            end
        end
        @(negedge sys_clk_i);
        {bus_mux_select_i, req_i} = {3'h4, 1'h1};
        repeat (3) @(negedge sys_clk_i);
        chk(busy_o, 1'h0);
        req_i = 1'h0;
        end_sim;
    end
    initial begin
        #100000;
        mismatches++;
        end_sim;
    end
endmodule // emt_ext_mem_timing_tb
